// >>> rtl/lrh_engine.sv
// LIN response table, wakeup and header engine with register port
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module lrh_engine #(
   parameter int BIT_CYCLES  = lrh_pkg::BIT_CYC,      // Clocks per bit
   parameter int WAKE_CYCLES = lrh_pkg::WAKE_CYC,     // Wakeup pulse clocks
   parameter int WAIT_CYCLES = lrh_pkg::HDR_WAIT_CYC  // Header wait clocks
) (
   input  wire logic        clock,    // 25 MHz system clock
   input  wire logic        reset,    // Synchronous reset, active high
   input  wire logic [4:0]  addr,     // Register byte address
   input  wire logic [31:0] wdata,    // Register write data
   input  wire logic        wr,       // Write strobe
   input  wire logic        rd,       // Read strobe
   output logic      [31:0] rdata,    // Read data, cycle after rd
   input  wire logic        lin_in,   // Bus level seen
   output logic             lin_out,  // Level driven when enabled
   output logic             lin_oe_n  // Low while driving dominant
);
   typedef enum logic [2:0] {S_IDLE, S_WAKE, S_WAITH, S_RXBRK, S_RXB,
                             S_HBRK, S_HDEL, S_TXB} lrh_state_t;

   localparam logic [23:0] T_BIT  = 24'(BIT_CYCLES - 1);
   localparam logic [23:0] T_HALF = 24'(BIT_CYCLES / 2 - 1);
   localparam logic [23:0] T_WAKE = 24'(WAKE_CYCLES - 1);
   localparam logic [23:0] T_WAIT = 24'(WAIT_CYCLES - 1);
   localparam logic [23:0] T_BRK  = 24'(BIT_CYCLES * lrh_pkg::BRK_TX_BITS - 1);
   // Break preceded by one recessive bit, used after a wakeup pulse
   localparam logic [23:0] T_GAP  =
      24'(BIT_CYCLES * (lrh_pkg::BRK_TX_BITS + 1) - 1);
   localparam logic [23:0] T_IDLE = 24'(BIT_CYCLES * lrh_pkg::IDLE_BITS - 1);
   localparam logic [23:0] N_BRK  = 24'(BIT_CYCLES * lrh_pkg::BRK_RX_BITS);

   lrh_state_t  state;
   logic [3:0]  tbl_len  [0:lrh_pkg::NUM_IDS-1];
   logic [63:0] tbl_data [0:lrh_pkg::NUM_IDS-1];
   logic [63:0] stage;
   logic [63:0] rxbuf;
   logic [7:0]  pend_type;
   logic [5:0]  pend_id;
   logic        pend;
   logic        sleep;
   logic        lchk;
   logic        master;
   logic        cmd_err;
   logic        rx_done;
   logic [23:0] tmr;
   logic [23:0] lowcnt;
   logic [3:0]  bitn;
   logic [3:0]  byt;
   logic [3:0]  tot;
   logic [9:0]  shreg;
   logic [7:0]  rxsh;
   logic [5:0]  cur_id;
   logic        tx_hdr;

   // Protected identifier: two parity bits over the six identifier bits
   function automatic logic [7:0] lrh_pid(input logic [5:0] id);
      lrh_pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]),
                 id[0] ^ id[1] ^ id[2] ^ id[4], id};
   endfunction

   // One byte of a stored response, framed with start and stop bits
   function automatic logic [9:0] lrh_frame(input logic [63:0] d,
                                            input logic [3:0]  k);
      lrh_frame = {1'b1, d[{k[2:0], 3'b000} +: 8], 1'b0};
   endfunction

   // Command word decode
   logic [7:0] c_type;
   logic [5:0] c_id;
   logic [3:0] c_len;
   logic       cmd_wr;
   logic       ctrl_wr;
   logic       resp_ok;
   logic       hdr_ok;
   assign c_type  = wdata[lrh_pkg::CMD_TYPE_LSB +: 8];
   assign c_id    = wdata[lrh_pkg::CMD_ID_LSB +: 6];
   assign c_len   = wdata[lrh_pkg::CMD_LEN_LSB +: 4];
   assign cmd_wr  = wr && addr == lrh_pkg::A_CMD;
   assign ctrl_wr = wr && addr == lrh_pkg::A_CTRL;
   assign resp_ok = c_type == lrh_pkg::TYPE_RESP && c_len <= lrh_pkg::MAX_LEN;
   assign hdr_ok  = c_type == lrh_pkg::TYPE_HDR && !pend &&
                    (!lchk || (c_len != 4'h0 && c_len <= lrh_pkg::MAX_LEN));

   // Events decoded from the state machine
   logic bit_end;
   logic hdr_rx;
   logic pend_clr;
   logic wake_hdr;
   assign bit_end  = tmr == 24'h0;
   assign hdr_rx   = state == S_RXB && bitn == 4'ha && bit_end &&
                     byt == 4'h1;
   assign wake_hdr = state == S_WAKE && bit_end && pend &&
                     pend_type == lrh_pkg::TYPE_HDR;
   assign pend_clr = (state == S_IDLE && pend && !sleep) ||
                     (state == S_WAKE && bit_end);

   // Response table lengths; reset makes every identifier a subscriber
   always_ff @(posedge clock) begin
      if (reset) begin
         for (int i = 0; i < lrh_pkg::NUM_IDS; i++) begin
            tbl_len[i] <= 4'h0;
         end
      end else if (cmd_wr && resp_ok) begin
         tbl_len[c_id] <= c_len;
      end
   end

   // Response table data, kept only for publishing entries
   always_ff @(posedge clock) begin
      if (cmd_wr && resp_ok && c_len != 4'h0) begin
         tbl_data[c_id] <= stage;
      end
   end

   // Staged data words for the next response entry
   always_ff @(posedge clock) begin
      if (reset) begin
         stage <= 64'h0;
      end else if (wr && addr == lrh_pkg::A_DLO) begin
         stage[31:0] <= wdata;
      end else if (wr && addr == lrh_pkg::A_DHI) begin
         stage[63:32] <= wdata;
      end
   end

   // Pending command for the state machine
   always_ff @(posedge clock) begin
      if (reset) begin
         pend      <= 1'b0;
         pend_type <= 8'h00;
         pend_id   <= 6'h00;
      end else begin
         if (pend_clr) begin
            pend <= 1'b0;
         end
         if (cmd_wr && (hdr_ok || (resp_ok && sleep && !pend))) begin
            pend      <= 1'b1;
            pend_type <= c_type;
            pend_id   <= c_id;
         end
      end
   end

   // Control bits; a software write lands after a hardware clear
   always_ff @(posedge clock) begin
      if (reset) begin
         sleep <= lrh_pkg::RST_SLEEP;
         lchk  <= lrh_pkg::RST_LCHK;
      end else begin
         if (hdr_rx || wake_hdr) begin
            sleep <= 1'b0;
         end
         if (ctrl_wr) begin
            sleep <= wdata[lrh_pkg::CTRL_SLEEP];
            lchk  <= wdata[lrh_pkg::CTRL_LCHK];
         end
      end
   end

   // Master role holds from the first header break until a restart written outside a header break
   always_ff @(posedge clock) begin
      if (reset) begin
         master <= 1'b0;
      end else begin
         if (ctrl_wr && wdata[lrh_pkg::CTRL_START]) begin
            master <= 1'b0;
         end
         if (state == S_HBRK) begin
            master <= 1'b1;
         end
      end
   end

   // Sticky status flags, cleared by a status read; an event wins
   always_ff @(posedge clock) begin
      if (reset) begin
         cmd_err <= 1'b0;
         rx_done <= 1'b0;
      end else begin
         if (rd && addr == lrh_pkg::A_STAT) begin
            cmd_err <= 1'b0;
            rx_done <= 1'b0;
         end
         if (cmd_wr && !resp_ok && !hdr_ok) begin
            cmd_err <= 1'b1;
         end
         if (state == S_RXB && bitn == 4'h0 && bit_end && byt > 4'h2) begin
            rx_done <= 1'b1;
         end
      end
   end

   // Register read port, data valid only in the cycle after rd
   always_ff @(posedge clock) begin
      if (reset || !rd) begin
         rdata <= 32'h0;
      end else begin
         case (addr)
            lrh_pkg::A_DLO:  rdata <= stage[31:0];
            lrh_pkg::A_DHI:  rdata <= stage[63:32];
            lrh_pkg::A_CTRL: rdata <= {30'h0, lchk, sleep};
            lrh_pkg::A_STAT: rdata <= {12'h0, byt, 2'b00, cur_id, 4'h0,
                                       rx_done, cmd_err,
                                       state != S_IDLE, master};
            lrh_pkg::A_RXLO: rdata <= rxbuf[31:0];
            lrh_pkg::A_RXHI: rdata <= rxbuf[63:32];
            default:         rdata <= 32'h0;
         endcase
      end
   end

   // Bus state machine: wakeup, break detection, byte receive and send
   always_ff @(posedge clock) begin
      if (reset) begin
         state    <= S_IDLE;
         tmr      <= 24'h0;
         lowcnt   <= 24'h0;
         bitn     <= 4'h0;
         byt      <= 4'h0;
         tot      <= 4'h0;
         shreg    <= 10'h3ff;
         rxsh     <= 8'h00;
         rxbuf    <= 64'h0;
         cur_id   <= 6'h00;
         tx_hdr   <= 1'b0;
         lin_out  <= 1'b0;
         lin_oe_n <= 1'b1;
      end else begin
         case (state)
            S_IDLE: begin
               if (pend && sleep) begin
                  state    <= S_WAKE;
                  tmr      <= T_WAKE;
                  lin_oe_n <= 1'b0;
               end else if (pend && pend_type == lrh_pkg::TYPE_HDR) begin
                  state    <= S_HBRK;
                  tmr      <= T_BRK;
                  cur_id   <= pend_id;
                  lin_oe_n <= 1'b0;
               end else if (!lin_in) begin
                  state  <= S_RXBRK;
                  lowcnt <= 24'h1;
               end
            end
            S_WAKE: begin
               if (!bit_end) begin
                  tmr <= tmr - 24'h1;
               end else if (wake_hdr) begin
                  // Release for one bit so the wakeup stands apart
                  state    <= S_HBRK;
                  tmr      <= T_GAP;
                  cur_id   <= pend_id;
                  lin_oe_n <= 1'b1;
               end else begin
                  state    <= S_WAITH;
                  tmr      <= T_WAIT;
                  lin_oe_n <= 1'b1;
               end
            end
            S_WAITH: begin
               if (!lin_in) begin
                  state  <= S_RXBRK;
                  lowcnt <= 24'h1;
               end else if (!sleep) begin
                  state <= S_IDLE;
               end else if (bit_end) begin
                  state    <= S_WAKE;
                  tmr      <= T_WAKE;
                  lin_oe_n <= 1'b0;
               end else begin
                  tmr <= tmr - 24'h1;
               end
            end
            S_RXBRK: begin
               if (!lin_in) begin
                  if (lowcnt != 24'hffffff) begin
                     lowcnt <= lowcnt + 24'h1;
                  end
               end else if (lowcnt >= N_BRK) begin
                  state <= S_RXB;
                  bitn  <= 4'h0;
                  byt   <= 4'h0;
                  tmr   <= T_IDLE;
               end else begin
                  state <= sleep ? S_WAITH : S_IDLE;
                  tmr   <= T_WAIT;
               end
            end
            S_RXB: begin
               if (bitn == 4'h0) begin
                  if (!lin_in) begin
                     bitn <= 4'h1;
                     tmr  <= T_HALF;
                  end else if (bit_end) begin
                     state <= S_IDLE;
                  end else begin
                     tmr <= tmr - 24'h1;
                  end
               end else if (!bit_end) begin
                  tmr <= tmr - 24'h1;
               end else if (bitn == 4'h1 && lin_in) begin
                  bitn <= 4'h0;                          // False start bit
                  tmr  <= T_IDLE;
               end else if (bitn != 4'ha) begin
                  bitn <= bitn + 4'h1;
                  tmr  <= T_BIT;
                  if (bitn != 4'h1) begin
                     rxsh <= {lin_in, rxsh[7:1]};
                  end
               end else begin
                  bitn <= 4'h0;
                  tmr  <= T_IDLE;
                  byt  <= byt + 4'h1;
                  if (byt == 4'h0 && rxsh != lrh_pkg::SYNC_BYTE) begin
                     state <= S_IDLE;
                  end else if (byt == 4'h1) begin
                     cur_id <= rxsh[5:0];
                     if (tbl_len[rxsh[5:0]] != 4'h0) begin
                        state    <= S_TXB;
                        tx_hdr   <= 1'b0;
                        tot      <= tbl_len[rxsh[5:0]];
                        byt      <= 4'h0;
                        shreg    <= lrh_frame(tbl_data[rxsh[5:0]], 4'h0);
                        tmr      <= T_BIT;
                        lin_oe_n <= 1'b0;
                     end
                  end else if (byt >= 4'h2) begin
                     rxbuf[{3'(byt - 4'h2), 3'b000} +: 8] <= rxsh;
                     if (byt == 4'h9) begin
                        state <= S_IDLE;
                     end
                  end
               end
            end
            S_HBRK: begin
               if (bit_end) begin
                  state    <= S_HDEL;
                  tmr      <= T_BIT;
                  lin_oe_n <= 1'b1;
               end else begin
                  tmr <= tmr - 24'h1;
                  if (tmr == T_BRK + 24'h1) begin
                     lin_oe_n <= 1'b0;
                  end
               end
            end
            S_HDEL: begin
               if (bit_end) begin
                  state    <= S_TXB;
                  tx_hdr   <= 1'b1;
                  byt      <= 4'h0;
                  bitn     <= 4'h0;
                  shreg    <= {1'b1, lrh_pkg::SYNC_BYTE, 1'b0};
                  tmr      <= T_BIT;
                  lin_oe_n <= 1'b0;
               end else begin
                  tmr <= tmr - 24'h1;
               end
            end
            S_TXB: begin
               if (!bit_end) begin
                  tmr <= tmr - 24'h1;
               end else if (bitn != 4'h9) begin
                  bitn     <= bitn + 4'h1;
                  shreg    <= {1'b1, shreg[9:1]};
                  lin_oe_n <= shreg[1];
                  tmr      <= T_BIT;
               end else begin
                  bitn <= 4'h0;
                  tmr  <= T_BIT;
                  if (tx_hdr && byt == 4'h0) begin
                     byt      <= 4'h1;
                     shreg    <= {1'b1, lrh_pid(cur_id), 1'b0};
                     lin_oe_n <= 1'b0;
                  end else if (tx_hdr) begin
                     state  <= S_RXB;
                     tx_hdr <= 1'b0;
                     byt    <= 4'h2;
                     tmr    <= T_IDLE;
                  end else if (byt + 4'h1 < tot) begin
                     byt      <= byt + 4'h1;
                     shreg    <= lrh_frame(tbl_data[cur_id], byt + 4'h1);
                     lin_oe_n <= 1'b0;
                  end else begin
                     state <= S_IDLE;
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   sequence asleep_pick_s;
      state == S_IDLE && pend && sleep;
   endsequence
   sequence hdr_pick_s;
      state == S_IDLE && pend && !sleep && pend_type == lrh_pkg::TYPE_HDR;
   endsequence

   resp_load_a: assert property (cmd_wr && resp_ok |=>
      tbl_len[$past(c_id)] == $past(c_len))
      else $error("response entry not stored");
   wake_start_a: assert property (asleep_pick_s |=>
      state == S_WAKE && !lin_oe_n)
      else $error("wakeup break not started");
   wake_retry_a: assert property (state == S_WAITH && lin_in &&
      sleep && bit_end |=> state == S_WAKE ##1 !lin_oe_n)
      else $error("wakeup break not repeated");
   hdr_wakes_a: assert property (hdr_rx |=> !sleep || $past(ctrl_wr))
      else $error("sleep not cleared by header");
   hdr_send_a: assert property (hdr_pick_s |=>
      state == S_HBRK ##1 !lin_oe_n [*3])
      else $error("header break not driven");
   master_hold_a: assert property (master &&
      !(ctrl_wr && wdata[lrh_pkg::CTRL_START]) |=> master)
      else $error("master role dropped");
   sleep_hdr_a: assert property (wake_hdr |=>
      state == S_HBRK && (!sleep || $past(ctrl_wr)))
      else $error("asleep header mishandled");
   len_check_a: assert property (cmd_wr && lchk && !pend &&
      c_type == lrh_pkg::TYPE_HDR && c_len == 4'h0 |=> cmd_err && !pend)
      else $error("bad header length accepted");
   subscribe_a: assert property (hdr_rx && tbl_len[rxsh[5:0]] == 4'h0
      |=> state == S_RXB && lin_oe_n)
      else $error("subscriber drove the bus");
endmodule

// >>> rtl/lrh_pkg.sv
// Constants shared by the LIN response and header engine
package lrh_pkg;
   localparam int CLK_NS       = 40;         // 25 MHz system clock period
   localparam int BIT_NS       = 52083;      // One LIN bit at 19200 baud
   localparam int BIT_CYC      = BIT_NS / CLK_NS;
   localparam int WAKE_NS      = 250000;     // Least wakeup pulse length
   localparam int WAKE_CYC     = (WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HDR_WAIT_NS  = 150000000;  // Longest wait for a header
   localparam int HDR_WAIT_CYC = HDR_WAIT_NS / CLK_NS;
   localparam int BRK_TX_BITS  = 13;         // Dominant bits sent as break
   localparam int BRK_RX_BITS  = 11;         // Dominant bits seen as break
   localparam int IDLE_BITS    = 20;         // Silence that ends a frame
   localparam int NUM_IDS      = 64;         // Identifiers 0 to 63
   localparam logic [3:0] MAX_LEN   = 4'h8;  // Longest response
   localparam logic [7:0] TYPE_RESP = 8'h10; // Response entry command
   localparam logic [7:0] TYPE_HDR  = 8'h11; // Header command
   localparam logic [7:0] SYNC_BYTE = 8'h55;
   // Register offsets
   localparam logic [4:0] A_CMD  = 5'h00;
   localparam logic [4:0] A_DLO  = 5'h04;
   localparam logic [4:0] A_DHI  = 5'h08;
   localparam logic [4:0] A_CTRL = 5'h0c;
   localparam logic [4:0] A_STAT = 5'h10;
   localparam logic [4:0] A_RXLO = 5'h14;
   localparam logic [4:0] A_RXHI = 5'h18;
   // Field positions
   localparam int CMD_TYPE_LSB = 0;
   localparam int CMD_ID_LSB   = 8;
   localparam int CMD_LEN_LSB  = 16;
   localparam int CTRL_SLEEP   = 0;
   localparam int CTRL_LCHK    = 1;
   localparam int CTRL_START   = 2;
   // Values after reset
   localparam logic RST_SLEEP = 1'b0;
   localparam logic RST_LCHK  = 1'b0;
endpackage

// >>> verif/lrh_lin_node.sv
// Behavioural LIN master and slave node on the far side of the bus
`timescale 1ns/1ps
module lrh_lin_node #(
   parameter int B = 8           // Clocks per bit
) (
   input  wire logic clock,      // System clock
   input  wire logic bus,        // Wired bus level, pulled up
   output logic      pull_low    // High while the node drives dominant
);
   initial pull_low = 1'b0;
   // Drive one level for n bit times; every sequence ends recessive
   task automatic drive(input logic v, input int n);
      pull_low <= !v;
      repeat (n * B) @(posedge clock);
   endtask
   // Send one byte: start bit, LSB first, stop bit
   task automatic send_byte(input logic [7:0] b);
      drive(1'b0, 1);
      for (int i = 0; i < 8; i++) drive(b[i], 1);
      drive(1'b1, 1);
   endtask
   // Acknowledge or poll as master: break, delimiter, sync, id
   task automatic send_header(input logic [7:0] pid);
      drive(1'b0, 13);
      drive(1'b1, 1);
      send_byte(8'h55);
      send_byte(pid);
   endtask
   // Wait up to lim clocks for the bus to show level v
   task automatic wait_lvl(input logic v, input int lim, output bit ok);
      ok = 1'b0;
      for (int i = 0; i < lim && !ok; i++) begin
         @(posedge clock);
         ok = (bus === v);
      end
   endtask
   // Count clocks while the bus holds level v, up to lim
   task automatic count_lvl(input logic v, input int lim, output int n);
      n = 0;
      while (bus === v && n < lim) begin
         @(posedge clock);
         n++;
      end
   endtask
   // After a start edge, sample eight data bits in mid-bit
   task automatic rx_rest(output logic [7:0] b);
      repeat (B / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         repeat (B) @(posedge clock);
         b[i] = bus;
      end
      repeat (B) @(posedge clock);
   endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the LIN response and header engine
`timescale 1ns/1ps
module tb_top;
   localparam int B = 8;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        wr    = 1'b0;
   logic        rd    = 1'b0;
   logic [4:0]  addr  = 5'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        lin_out;
   logic        lin_oe_n;
   logic        pull_low;
   logic        bus;
   int          n_fail  = 0;
   int          checked = 0;
   // Open-drain bus with pull-up
   assign bus = (lin_oe_n | lin_out) & !pull_low;
   always #20 clock = !clock;
   lrh_engine #(.BIT_CYCLES(B), .WAKE_CYCLES(20), .WAIT_CYCLES(400))
      lrh_engine_i (.clock(clock), .reset(reset), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .lin_in(bus),
      .lin_out(lin_out), .lin_oe_n(lin_oe_n));
   lrh_lin_node #(.B(B)) lrh_lin_node_i (.clock(clock), .bus(bus),
      .pull_low(pull_low));
   task automatic give_verdict;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock);
      wr    <= 1'b0;
   endtask
   task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock);
      rd   <= 1'b0;
      // Data stand in this cycle only; take them at its closing edge
      @(posedge clock);
      d = rdata;
   endtask
   // Bounded wait for a bus level; a timeout ends the run
   task automatic wl(input logic v, input int lim);
      bit ok;
      lrh_lin_node_i.wait_lvl(v, lim, ok);
      if (!ok) begin
         chk(32'(v), 32'(!v));
         give_verdict();
      end
   endtask
   task automatic gb(output logic [7:0] b);
      wl(1'b0, 40 * B);
      lrh_lin_node_i.rx_rest(b);
   endtask
   function automatic logic [7:0] pid(input logic [5:0] i);
      return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
   endfunction
   function automatic logic [31:0] cmd(input logic [7:0] t,
                                       input logic [5:0] id,
                                       input logic [3:0] len);
      return {12'h000, len, 2'b00, id, t};
   endfunction
   // Load an entry unless len is 15, send its header, check the device's answer, or for len 0 and 15 the byte it received
   task automatic resp(input logic [5:0] id, input logic [3:0] len,
                       input logic [63:0] pub, input logic [7:0] sb);
      logic [7:0]  b;
      logic [31:0] d;
      wr_reg(lrh_pkg::A_DLO, pub[31:0]);
      wr_reg(lrh_pkg::A_DHI, pub[63:32]);
      if (len != 4'hf)
         wr_reg(lrh_pkg::A_CMD, cmd(lrh_pkg::TYPE_RESP, id, len));
      lrh_lin_node_i.send_header(pid(id));
      if (len == 4'hf || len == 4'h0) begin
         lrh_lin_node_i.send_byte(sb);
         repeat (24 * B) @(posedge clock);
         rd_reg(lrh_pkg::A_RXLO, d);
         chk(d & 32'hff, {24'h0, sb});
      end else begin
         for (int i = 0; i < len; i++) begin
            gb(b);
            chk({24'h0, b}, {24'h0, pub[8 * i +: 8]});
         end
         repeat (24 * B) @(posedge clock);
      end
   endtask
   // Check one device header: break length, sync byte, protected id
   task automatic hdr(input logic [5:0] id, input int lim);
      int         n;
      logic [7:0] b;
      wl(1'b0, lim);
      chk({31'h0, lin_out}, 32'h0);
      lrh_lin_node_i.count_lvl(1'b0, 200, n);
      chk(32'(n), 32'(13 * B));
      gb(b);
      chk({24'h0, b}, 32'h55);
      gb(b);
      chk({24'h0, b}, {24'h0, pid(id)});
      // Let the identifier's stop bit finish before any reply
      repeat (B / 2) @(posedge clock);
   endtask
   // Watchdog for the whole run
   initial begin
      repeat (100000) @(posedge clock);
      chk(32'h1, 32'h0);
      give_verdict();
   end
   initial begin
      logic [31:0] d;
      logic [5:0]  id;
      logic [7:0]  sb;
      int          n;
      bit          ok;
      void'($urandom(18480));
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      rd_reg(lrh_pkg::A_STAT, d);
      chk(d, 32'h0);
      rd_reg(5'h1c, d);
      chk(d, 32'h0);
      // Published entries: top id, then random ids and lengths
      resp(6'd63, 4'h8, {$urandom, $urandom}, 8'h00);
      for (int k = 0; k < 3; k++)
         resp(6'($urandom_range(61, 1)), 4'($urandom_range(8, 1)),
              {$urandom, $urandom}, 8'h00);
      // Subscribe: explicit zero length, then a never-written id
      resp(6'd0, 4'h0, {$urandom, $urandom}, 8'($urandom));
      resp(6'd62, 4'hf, 64'h0, 8'($urandom));
      // Asleep entry: wakeup pulse, retry, then header ends sleep
      wr_reg(lrh_pkg::A_CTRL, 32'h1);
      wr_reg(lrh_pkg::A_DLO, 32'h000000a5);
      wr_reg(lrh_pkg::A_CMD, cmd(lrh_pkg::TYPE_RESP, 6'd5, 4'h1));
      wl(1'b0, 50);
      lrh_lin_node_i.count_lvl(1'b0, 100, n);
      chk(32'(n), 32'd20);
      lrh_lin_node_i.count_lvl(1'b1, 600, n);
      chk(32'(n > 390 && n < 430), 32'h1);
      lrh_lin_node_i.count_lvl(1'b0, 100, n);
      chk(32'(n), 32'd20);
      resp(6'd5, 4'hf - 4'he, 64'ha5, 8'h00);
      lrh_lin_node_i.wait_lvl(1'b0, 600, ok);
      chk(32'(ok), 32'h0);
      // Header commands with length check on: refused lengths and type
      wr_reg(lrh_pkg::A_CTRL, 32'h2);
      for (int j = 0; j < 2; j++) begin
         wr_reg(lrh_pkg::A_CMD, cmd(lrh_pkg::TYPE_HDR, 6'd9, j ? 4'h9 : 4'h0));
         rd_reg(lrh_pkg::A_STAT, d);
         chk(d & 32'h4, 32'h4);
      end
      wr_reg(lrh_pkg::A_CMD, cmd(8'h12, 6'd9, 4'h1));
      rd_reg(lrh_pkg::A_STAT, d);
      chk(d & 32'h4, 32'h4);
      // Accepted header, then an external slave publishes two bytes
      id = 6'($urandom);
      wr_reg(lrh_pkg::A_CMD, cmd(lrh_pkg::TYPE_HDR, id, 4'h8));
      hdr(id, 4);
      sb = 8'($urandom);
      lrh_lin_node_i.send_byte(sb);
      lrh_lin_node_i.send_byte(~sb);
      repeat (24 * B) @(posedge clock);
      rd_reg(lrh_pkg::A_RXLO, d);
      chk(d & 32'hffff, {16'h0, ~sb, sb});
      rd_reg(lrh_pkg::A_STAT, d);
      chk(d & 32'h9, 32'h9);
      // Length check off: zero length header goes out
      wr_reg(lrh_pkg::A_CTRL, 32'h0);
      wr_reg(lrh_pkg::A_CMD, cmd(lrh_pkg::TYPE_HDR, 6'd33, 4'h0));
      hdr(6'd33, 4);
      repeat (24 * B) @(posedge clock);
      // Asleep header: wakeup pulse, header, then no more wakeups
      wr_reg(lrh_pkg::A_CTRL, 32'h1);
      wr_reg(lrh_pkg::A_CMD, cmd(lrh_pkg::TYPE_HDR, 6'd17, 4'h2));
      wl(1'b0, 50);
      lrh_lin_node_i.count_lvl(1'b0, 100, n);
      chk(32'(n), 32'd20);
      hdr(6'd17, 600);
      lrh_lin_node_i.wait_lvl(1'b0, 24 * B + 600, ok);
      chk(32'(ok), 32'h0);
      // Restart drops the master role
      wr_reg(lrh_pkg::A_CTRL, 32'h4);
      rd_reg(lrh_pkg::A_STAT, d);
      chk(d & 32'h1, 32'h0);
      give_verdict();
   end
endmodule
